// >>> agl_pkg.sv
/*
 * Shared constants, types and interval tables for the recording-path gain
 * leveler timing block: register offsets, field positions, reset values,
 * leveler states and the hold, decay and attack tables in microseconds.
 * Assumes a single 125 MHz register and audio clock.
 */
package agl_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_TEST_SRC = 8'h1C;
	localparam logic [7:0] ADDR_STYLE_HOLD = 8'h40;
	localparam logic [7:0] ADDR_RAMP = 8'h44;
	localparam logic [7:0] ADDR_MODE = 8'h48;
	localparam logic [7:0] ADDR_STATUS = 8'h60;

	// Field positions
	localparam int TS_LEFT_VAL_LSB = 4;
	localparam int TS_RIGHT_VAL_LSB = 2;
	localparam int TS_LEFT_SEL_BIT = 1;
	localparam int TS_RIGHT_SEL_BIT = 0;
	localparam int SH_ATT_STYLE_BIT = 6;
	localparam int SH_CTRL_LSB = 4;
	localparam int SH_HOLD_LSB = 0;
	localparam int RT_DECAY_LSB = 4;
	localparam int RT_ATTACK_LSB = 0;
	localparam int MD_LIMITER_BIT = 7;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_LIMITER_BIT = 2;

	// Reset values and range limits of the coded fields
	localparam logic [3:0] HOLD_RST = 4'h0;
	localparam logic [3:0] DECAY_RST = 4'h4;
	localparam logic [3:0] ATTACK_RST = 4'h6;
	localparam logic [3:0] CODE_MAX = 4'hA;
	localparam logic [3:0] DECAY_CLAMP = 4'hA;
	localparam logic [3:0] SHORT_CODE = 4'h0;

	// Reference tick: 1 us at 125 MHz
	localparam int CLK_FREQ_MHZ = 125;
	localparam int TICK_US = 1;
	localparam int TICK_CYC = TICK_US * CLK_FREQ_MHZ;
	localparam int TICK_W = 8;
	localparam int INTERVAL_W = 20;

	typedef logic [INTERVAL_W-1:0] agl_us_t;

	// Interval tables, in reference ticks of 1 us
	localparam agl_us_t HOLD_TBL [0:10] = '{20'h00000, 20'h007D0, 20'h00FA0, 20'h01F40,
		20'h03E80, 20'h07D00, 20'h0FA00, 20'h1F400, 20'h3E800, 20'h7D000, 20'hF4240};
	localparam agl_us_t DECAY_NORM_TBL [0:10] = '{20'h001F4, 20'h003E8, 20'h007D0,
		20'h00FA0, 20'h01F40, 20'h03E80, 20'h07D00, 20'h0FA00, 20'h1F400, 20'h3E800,
		20'h7D000};
	localparam agl_us_t RAMP_125_TBL [0:10] = '{20'h0007D, 20'h000FA, 20'h001F4,
		20'h003E8, 20'h007D0, 20'h00FA0, 20'h01F40, 20'h03E80, 20'h07D00, 20'h0FA00,
		20'h1F400};
	localparam agl_us_t ATTACK_LIM_TBL [0:10] = '{20'h00020, 20'h00040, 20'h0007D,
		20'h000FA, 20'h001F4, 20'h003E8, 20'h007D0, 20'h00FA0, 20'h01F40, 20'h03E80,
		20'h07D00};

	// Leveler states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01,
		ST_RISE = 2'b10,
		ST_FALL = 2'b11
	} agl_state_t;

	// Source selector settings
	typedef struct packed {
		logic [1:0] left_injected_value;
		logic [1:0] right_injected_value;
		logic left_source_select;
		logic right_source_select;
	} agl_src_cfg_t;

	// Leveler settings
	typedef struct packed {
		logic limiter;
		logic gain_attack_style;
		logic [1:0] control_signal_style;
		logic [3:0] hold;
		logic [3:0] decay;
		logic [3:0] attack;
	} agl_lev_cfg_t;

	localparam agl_src_cfg_t SRC_RST = '0;
	localparam agl_lev_cfg_t LEV_RST = '{limiter: 1'b0, gain_attack_style: 1'b0,
		control_signal_style: 2'b00, hold: HOLD_RST, decay: DECAY_RST, attack: ATTACK_RST};

	// Hold interval; out-of-range codes give none
	function automatic agl_us_t hold_us(input logic [3:0] code);
		hold_us = (code > CODE_MAX) ? HOLD_TBL[SHORT_CODE] : HOLD_TBL[code];
	endfunction : hold_us

	// Decay interval; out-of-range codes clamp to the longest
	function automatic agl_us_t decay_us(input logic lim, input logic [3:0] code);
		logic [3:0] c;
		c = (code > CODE_MAX) ? DECAY_CLAMP : code;
		decay_us = lim ? RAMP_125_TBL[c] : DECAY_NORM_TBL[c];
	endfunction : decay_us

	// Attack interval; out-of-range codes give the shortest
	function automatic agl_us_t attack_us(input logic lim, input logic [3:0] code);
		logic [3:0] c;
		c = (code > CODE_MAX) ? SHORT_CODE : code;
		attack_us = lim ? ATTACK_LIM_TBL[c] : RAMP_125_TBL[c];
	endfunction : attack_us

endpackage : agl_pkg

// >>> agl_interval_timer.sv
/*
 * Interval timer: counts reference ticks while run is high and pulses done
 * for one cycle each time the target count is reached, then starts again.
 * Assumes tick is a one-cycle pulse in the same clock domain.
 */
`timescale 1ns/10ps
module agl_interval_timer #(
	parameter int CNT_W = agl_pkg::INTERVAL_W
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic tick,
	input wire logic [CNT_W-1:0] target,
	// Result
	output logic done
);
	import agl_pkg::*;

	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic done_q, done_d;

	// Next count; a zero target fires every cycle
	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (!run) begin
			cnt_d = '0;
		end else if (target == '0) begin
			done_d = 1'b1;
		end else if (tick) begin
			if (cnt_q + 1'b1 >= target) begin
				done_d = 1'b1;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	// Count registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;

endmodule : agl_interval_timer

// >>> agl_leveler_timing.sv
/*
 * Recording-path gain leveler timing with per-channel source selector and
 * an APB register slave. Produces gain step pulses for the gain core.
 * Assumes APB signals, converter data and leveler requests are synchronous
 * to pclk, and that the gain core applies the step pulses and style selects.
 */
// The APB slave port is this design's own decision.
// Summary of operation
// - Left path takes converter data, or left injected value when selected.
// - Right path takes converter data, or right injected value when selected.
// - Attack style bit picks conventional or jack-style attack control.
// - Two-bit control style field picks conventional or one of three jack styles.
// - Normal mode waits the coded hold time before raising gain.
// - Decay code maps to doubling tables per mode, high codes clamp longest.
// - Attack code maps to doubling tables per mode, high codes give shortest.
// - Limiter bit selects limiter tables instead of normal leveling tables.
`timescale 1ns/10ps
module agl_leveler_timing #(
	parameter int DATA_W = 24,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter data in, recording data out
	input wire logic [DATA_W-1:0] adc_left_in,
	input wire logic [DATA_W-1:0] adc_right_in,
	output logic [DATA_W-1:0] rec_left_out,
	output logic [DATA_W-1:0] rec_right_out,
	// Leveler requests from the level detector
	input wire logic gain_rise_req,
	input wire logic gain_fall_req,
	// Leveler controls to the gain core
	output logic gain_up_step,
	output logic gain_down_step,
	output logic hold_active,
	output logic limiter_active,
	output logic gain_attack_style,
	output logic [1:0] control_signal_style
);
	import agl_pkg::*;

	localparam int NUM_CH = 2;
	localparam int CH_L = 0;
	localparam int CH_R = 1;
	localparam int NUM_TMR = 3;
	localparam int TMR_HOLD = 0;
	localparam int TMR_DECAY = 1;
	localparam int TMR_ATTACK = 2;
	localparam int TICK_GAP = TICK_CYC;
	localparam int TICK_GAP_M1 = TICK_GAP - 1;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

	agl_src_cfg_t src_q, src_d;
	agl_lev_cfg_t lev_q, lev_d;
	agl_state_t state_q, state_d;
	logic [31:0] prdata_q, prdata_d;
	logic [31:0] rd_word;
	logic hit_src, hit_sh, hit_rt, hit_md, hit_st, mapped;
	logic wr_en;
	logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;
	logic kick_q, kick_d;
	logic [NUM_CH-1:0] ch_sel;
	logic [1:0] ch_val [NUM_CH];
	logic [DATA_W-1:0] ch_in [NUM_CH];
	logic [DATA_W-1:0] ch_out_q [NUM_CH];
	logic [NUM_TMR-1:0] tmr_run;
	logic [NUM_TMR-1:0] tmr_done;
	agl_us_t tmr_target [NUM_TMR];

	// Address decode
	always_comb begin
		hit_src = 1'b0;
		hit_sh = 1'b0;
		hit_rt = 1'b0;
		hit_md = 1'b0;
		hit_st = 1'b0;
		if (paddr == ADDR_W'(ADDR_TEST_SRC)) begin
			hit_src = 1'b1;
		end else if (paddr == ADDR_W'(ADDR_STYLE_HOLD)) begin
			hit_sh = 1'b1;
		end else if (paddr == ADDR_W'(ADDR_RAMP)) begin
			hit_rt = 1'b1;
		end else if (paddr == ADDR_W'(ADDR_MODE)) begin
			hit_md = 1'b1;
		end else if (paddr == ADDR_W'(ADDR_STATUS)) begin
			hit_st = 1'b1;
		end
		mapped = hit_src | hit_sh | hit_rt | hit_md | hit_st;
		wr_en = psel & penable & pwrite;
	end

	// Read word assembly; reserved bits read zero
	always_comb begin
		rd_word = '0;
		if (hit_src) begin
			rd_word[TS_LEFT_VAL_LSB +: 2] = src_q.left_injected_value;
			rd_word[TS_RIGHT_VAL_LSB +: 2] = src_q.right_injected_value;
			rd_word[TS_LEFT_SEL_BIT] = src_q.left_source_select;
			rd_word[TS_RIGHT_SEL_BIT] = src_q.right_source_select;
		end else if (hit_sh) begin
			rd_word[SH_ATT_STYLE_BIT] = lev_q.gain_attack_style;
			rd_word[SH_CTRL_LSB +: 2] = lev_q.control_signal_style;
			rd_word[SH_HOLD_LSB +: 4] = lev_q.hold;
		end else if (hit_rt) begin
			rd_word[RT_DECAY_LSB +: 4] = lev_q.decay;
			rd_word[RT_ATTACK_LSB +: 4] = lev_q.attack;
		end else if (hit_md) begin
			rd_word[MD_LIMITER_BIT] = lev_q.limiter;
		end else if (hit_st) begin
			rd_word[ST_STATE_LSB +: 2] = state_q;
			rd_word[ST_LIMITER_BIT] = lev_q.limiter;
		end
	end

	// Register writes in the access phase; read data caught in setup
	always_comb begin
		src_d = src_q;
		lev_d = lev_q;
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			prdata_d = rd_word;
		end
		if (wr_en && hit_src) begin
			src_d.left_injected_value = pwdata[TS_LEFT_VAL_LSB +: 2];
			src_d.right_injected_value = pwdata[TS_RIGHT_VAL_LSB +: 2];
			src_d.left_source_select = pwdata[TS_LEFT_SEL_BIT];
			src_d.right_source_select = pwdata[TS_RIGHT_SEL_BIT];
		end else if (wr_en && hit_sh) begin
			lev_d.gain_attack_style = pwdata[SH_ATT_STYLE_BIT];
			lev_d.control_signal_style = pwdata[SH_CTRL_LSB +: 2];
			lev_d.hold = pwdata[SH_HOLD_LSB +: 4];
		end else if (wr_en && hit_rt) begin
			lev_d.decay = pwdata[RT_DECAY_LSB +: 4];
			lev_d.attack = pwdata[RT_ATTACK_LSB +: 4];
		end else if (wr_en && hit_md) begin
			lev_d.limiter = pwdata[MD_LIMITER_BIT];
		end
	end

	// Register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= SRC_RST;
			lev_q <= LEV_RST;
			prdata_q <= '0;
		end else begin
			src_q <= src_d;
			lev_q <= lev_d;
			prdata_q <= prdata_d;
		end
	end

	// Zero-wait slave; unmapped addresses answer with an error
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Per-channel source selector
	assign ch_sel = {src_q.right_source_select, src_q.left_source_select};
	assign ch_val[CH_L] = src_q.left_injected_value;
	assign ch_val[CH_R] = src_q.right_injected_value;
	assign ch_in[CH_L] = adc_left_in;
	assign ch_in[CH_R] = adc_right_in;

	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_src
			logic [DATA_W-1:0] out_d;
			// Injected value sits in the low bits
			always_comb begin
				out_d = ch_sel[ch] ? {{(DATA_W-2){1'b0}}, ch_val[ch]} : ch_in[ch];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ch_out_q[ch] <= '0;
				end else begin
					ch_out_q[ch] <= out_d;
				end
			end
		end
	endgenerate

	assign rec_left_out = ch_out_q[CH_L];
	assign rec_right_out = ch_out_q[CH_R];

	// Reference tick divider
	always_comb begin
		tick_d = 1'b0;
		tick_cnt_d = tick_cnt_q + 1'b1;
		if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	// Leveler sequence; a fall request always wins
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE, ST_FALL: begin
				if (gain_fall_req) begin
					state_d = ST_FALL;
				end else if (gain_rise_req) begin
					state_d = lev_q.limiter ? ST_RISE : ST_HOLD;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (gain_fall_req) begin
					state_d = ST_FALL;
				end else if (!gain_rise_req) begin
					state_d = ST_IDLE;
				end else if (lev_q.limiter || tmr_done[TMR_HOLD]) begin
					state_d = ST_RISE;
				end
			end
			ST_RISE: begin
				if (gain_fall_req) begin
					state_d = ST_FALL;
				end else if (!gain_rise_req) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// Jack-style attack steps at once on entering a fall
		kick_d = lev_q.gain_attack_style && state_q != ST_FALL && state_d == ST_FALL;
	end

	// Sequencer and tick registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
			kick_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
			kick_q <= kick_d;
		end
	end

	// Interval targets follow the mode tables
	assign tmr_target[TMR_HOLD] = hold_us(lev_q.hold);
	assign tmr_target[TMR_DECAY] = decay_us(lev_q.limiter, lev_q.decay);
	assign tmr_target[TMR_ATTACK] = attack_us(lev_q.limiter, lev_q.attack);
	assign tmr_run[TMR_HOLD] = (state_q == ST_HOLD);
	assign tmr_run[TMR_DECAY] = (state_q == ST_RISE);
	assign tmr_run[TMR_ATTACK] = (state_q == ST_FALL);

	generate
		for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
			agl_interval_timer #(
				.CNT_W(INTERVAL_W)
			) u_timer (
				.pclk(pclk),
				.presetn(presetn),
				.run(tmr_run[t]),
				.tick(tick_q),
				.target(tmr_target[t]),
				.done(tmr_done[t])
			);
		end
	endgenerate

	// Outputs to the gain core
	assign gain_up_step = tmr_done[TMR_DECAY];
	assign gain_down_step = tmr_done[TMR_ATTACK] | kick_q;
	assign hold_active = (state_q == ST_HOLD);
	assign limiter_active = lev_q.limiter;
	assign gain_attack_style = lev_q.gain_attack_style;
	assign control_signal_style = lev_q.control_signal_style;

	// Tick counts between steps, for checking only
	logic [INTERVAL_W-1:0] up_ticks_q, dn_ticks_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_ticks_q <= '0;
			dn_ticks_q <= '0;
		end else begin
			up_ticks_q <= !tmr_run[TMR_DECAY] ? '0 :
				(tmr_done[TMR_DECAY] ? INTERVAL_W'(tick_q) : up_ticks_q + INTERVAL_W'(tick_q));
			dn_ticks_q <= !tmr_run[TMR_ATTACK] ? '0 :
				(tmr_done[TMR_ATTACK] ? INTERVAL_W'(tick_q) : dn_ticks_q + INTERVAL_W'(tick_q));
		end
	end

	sequence s_style_write;
		psel && penable && pwrite && hit_sh;
	endsequence

	chk_left_inject: assert property (@(posedge pclk) disable iff (!presetn)
		src_q.left_source_select |=> rec_left_out == {{(DATA_W-2){1'b0}},
		$past(src_q.left_injected_value)})
		else $error("left injected value not on recording path");
	chk_left_normal: assert property (@(posedge pclk) disable iff (!presetn)
		!src_q.left_source_select |=> rec_left_out == $past(adc_left_in))
		else $error("left converter data not on recording path");
	chk_right_inject: assert property (@(posedge pclk) disable iff (!presetn)
		src_q.right_source_select |=> rec_right_out == {{(DATA_W-2){1'b0}},
		$past(src_q.right_injected_value)})
		else $error("right injected value not on recording path");
	chk_right_normal: assert property (@(posedge pclk) disable iff (!presetn)
		!src_q.right_source_select |=> rec_right_out == $past(adc_right_in))
		else $error("right converter data not on recording path");
	// Entry into a fall while the jack-style attack is chosen
	sequence s_fall_entry;
		gain_attack_style && state_q != ST_FALL ##1 state_q == ST_FALL;
	endsequence

	chk_jack_attack: assert property (@(posedge pclk) disable iff (!presetn)
		s_fall_entry |-> gain_down_step)
		else $error("jack-style attack missed its first step");
	chk_ctrl_style: assert property (@(posedge pclk) disable iff (!presetn)
		s_style_write |=> control_signal_style == $past(pwdata[SH_CTRL_LSB +: 2]))
		else $error("control style not taken from write");
	chk_hold_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_HOLD && tmr_target[TMR_HOLD] == '0) |-> ##[1:3] state_q != ST_HOLD)
		else $error("zero hold did not end at once");
	chk_hold_wait: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(hold_active) && !lev_q.limiter && tmr_target[TMR_HOLD] != '0)
		|-> (state_q != ST_RISE)[*8])
		else $error("gain rose before hold interval");
	chk_decay_period: assert property (@(posedge pclk) disable iff (!presetn)
		(gain_up_step && up_ticks_q != '0) |-> up_ticks_q == tmr_target[TMR_DECAY])
		else $error("decay step spacing wrong");
	chk_attack_period: assert property (@(posedge pclk) disable iff (!presetn)
		(tmr_done[TMR_ATTACK] && dn_ticks_q != '0) |-> dn_ticks_q == tmr_target[TMR_ATTACK])
		else $error("attack step spacing wrong");
	chk_limiter_nohold: assert property (@(posedge pclk) disable iff (!presetn)
		lev_q.limiter |=> state_q != ST_HOLD)
		else $error("hold entered in limiter mode");
	chk_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
		tick_q |-> ##1 !tick_q ##TICK_GAP_M1 tick_q)
		else $error("reference tick period wrong");

endmodule : agl_leveler_timing

// >>> tb_top.sv
/*
 * Self-checking bench for the gain leveler timing block: register reset
 * values and writable bits, source selector, style outputs, hold interval,
 * attack intervals in both modes and the limiter decay interval. Assumes one 125 MHz clock for APB.
 */
`timescale 1ns/10ps
module tb_top;
	import agl_pkg::*;

	// Block ports and bench counters
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [23:0] adc_left_in = 24'h0;
	logic [23:0] adc_right_in = 24'h0;
	logic [23:0] rec_left_out;
	logic [23:0] rec_right_out;
	logic gain_rise_req = 1'b0;
	logic gain_fall_req = 1'b0;
	logic gain_up_step;
	logic gain_down_step;
	logic hold_active;
	logic limiter_active;
	logic gain_attack_style;
	logic [1:0] control_signal_style;
	int errors = 0;
	int samples_checked = 0;

	// Block under test
	agl_leveler_timing agl_leveler_timing_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_left_in(adc_left_in),
		.adc_right_in(adc_right_in), .rec_left_out(rec_left_out), .rec_right_out(rec_right_out),
		.gain_rise_req(gain_rise_req), .gain_fall_req(gain_fall_req),
		.gain_up_step(gain_up_step), .gain_down_step(gain_down_step),
		.hold_active(hold_active), .limiter_active(limiter_active),
		.gain_attack_style(gain_attack_style), .control_signal_style(control_signal_style));

	// Clock at 125 MHz
	initial begin
		forever #4 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic wrap_up();
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// Compare one value
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			errors++;
		end
	endtask : check

	// A wait that ran out ends the run
	task automatic fail_timeout(input string name);
		$display("mismatch %s expected completion seen timeout", name);
		errors++;
		wrap_up();
	endtask : fail_timeout

	// One APB transfer, held until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail_timeout("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer

	task automatic apb_write(input logic [7:0] addr, input logic [31:0] wd);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b1, addr, wd, rd, err);
	endtask : apb_write

	task automatic reg_check(input string name, input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b0, addr, 32'h0, rd, err);
		check(name, exp, rd);
	endtask : reg_check

	// Wait for the next gain step pulse of one direction
	task automatic wait_step(input logic down, input int lim, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((down ? gain_down_step : gain_up_step) !== 1'b1 && n < lim);
		if (n >= lim) fail_timeout("gain step");
	endtask : wait_step

	// Spacing of two consecutive step pulses, within two cycles
	task automatic step_period(input string name, input logic down, input int exp);
		int n;
		wait_step(down, exp + 500, n);
		wait_step(down, exp + 500, n);
		samples_checked++;
		if (n < exp - 2 || n > exp + 2) begin
			$display("mismatch %s expected %0d seen %0d", name, exp, n);
			errors++;
		end
	endtask : step_period

	// Pass through hold or rise back to idle
	task automatic go_idle();
		gain_fall_req <= 1'b0;
		gain_rise_req <= 1'b1;
		repeat (3) @(posedge pclk);
		gain_rise_req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : go_idle

	// Reset values, writable bits, unmapped address
	task automatic t_registers();
		logic [7:0] addrs [4] = '{8'h1C, 8'h40, 8'h44, 8'h48};
		logic [31:0] rstv [4] = '{32'h0, 32'h0, 32'h46, 32'h0};
		logic [31:0] maskv [4] = '{32'h3F, 32'h7F, 32'hFF, 32'h80};
		logic [31:0] rd;
		logic err;
		for (int i = 0; i < 4; i++) begin
			reg_check("reset value", addrs[i], rstv[i]);
			apb_write(addrs[i], 32'hFFFFFFFF);
			reg_check("writable bits", addrs[i], maskv[i]);
			apb_write(addrs[i], rstv[i]);
		end
		reg_check("status idle", 8'h60, 32'h0);
		apb_xfer(1'b0, 8'h20, 32'h0, rd, err);
		check("unmapped error", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
	endtask : t_registers

	// Source selector per channel, and one-cycle data latency
	task automatic t_source();
		adc_left_in <= 24'h5A5A5A;
		adc_right_in <= 24'hC3C3C3;
		apb_write(8'h1C, 32'h32);
		repeat (2) @(posedge pclk);
		check("left injected", 32'h3, {8'h0, rec_left_out});
		check("right normal", 32'hC3C3C3, {8'h0, rec_right_out});
		apb_write(8'h1C, 32'h1D);
		repeat (2) @(posedge pclk);
		check("left normal", 32'h5A5A5A, {8'h0, rec_left_out});
		check("right injected", 32'h3, {8'h0, rec_right_out});
		apb_write(8'h1C, 32'h0);
		repeat (2) @(posedge pclk);
		check("right restored", 32'hC3C3C3, {8'h0, rec_right_out});
		adc_left_in <= 24'h123456;
		@(posedge pclk);
		check("left before", 32'h5A5A5A, {8'h0, rec_left_out});
		@(posedge pclk);
		check("left after", 32'h123456, {8'h0, rec_left_out});
	endtask : t_source

	// Every style code reaches the gain core
	task automatic t_styles();
		for (int s = 0; s < 4; s++) begin
			for (int a = 0; a < 2; a++) begin
				apb_write(8'h40, {25'h0, a[0], s[1:0], 4'h0});
				@(posedge pclk);
				check("control style", s, {30'h0, control_signal_style});
				check("attack style", a, {31'h0, gain_attack_style});
			end
		end
	endtask : t_styles

	// Cycles spent in hold for one code, capped
	task automatic hold_len(input logic [3:0] code, input int cap, input int exp);
		int n;
		int len;
		logic up;
		apb_write(8'h40, {28'h0, code});
		gain_rise_req <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (hold_active !== 1'b1 && n < 20);
		if (hold_active !== 1'b1) fail_timeout("hold entry");
		len = 0;
		up = 1'b0;
		while (hold_active === 1'b1 && len < cap) begin
			@(posedge pclk);
			len++;
			up = up | (gain_up_step === 1'b1);
		end
		check("hold length", exp, len);
		check("step in hold", 32'h0, {31'h0, up});
		gain_rise_req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : hold_len

	// Early attack step appears only with the jack style
	task automatic t_jack(input logic style);
		logic seen;
		apb_write(8'h40, {25'h0, style, 6'h0});
		go_idle();
		gain_fall_req <= 1'b1;
		seen = 1'b0;
		repeat (10) begin
			@(posedge pclk);
			seen = seen | (gain_down_step === 1'b1);
		end
		check("early attack step", {31'h0, style}, {31'h0, seen});
		go_idle();
	endtask : t_jack

	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_registers();
		t_source();
		t_styles();
		// Zero hold: one cycle for the timer to fire, one to leave
		hold_len(4'h0, 2000, 2);
		hold_len(4'hB, 2000, 2);
		hold_len(4'h1, 1000, 1000);
		apb_write(8'h40, 32'h0);
		apb_write(8'h48, 32'h80);
		@(posedge pclk);
		check("limiter flag", 32'h1, {31'h0, limiter_active});
		reg_check("status limiter", 8'h60, 32'h4);
		apb_write(8'h44, 32'h40);
		gain_fall_req <= 1'b1;
		step_period("limiter attack 0", 1'b1, 32 * TICK_CYC);
		apb_write(8'h44, 32'h4B);
		step_period("limiter attack 11", 1'b1, 32 * TICK_CYC);
		apb_write(8'h48, 32'h0);
		step_period("normal attack 11", 1'b1, 125 * TICK_CYC);
		go_idle();
		apb_write(8'h48, 32'h80);
		apb_write(8'h44, 32'h40);
		t_jack(1'b1);
		t_jack(1'b0);
		apb_write(8'h44, 32'h00);
		gain_rise_req <= 1'b1;
		step_period("limiter decay 0", 1'b0, 125 * TICK_CYC);
		gain_rise_req <= 1'b0;
		wrap_up();
	end

endmodule : tb_top
